// >>> mmsi_baud_gen.sv
// Baud rate tick generator
`timescale 1ns/1ps
module mmsi_baud_gen #(
	parameter int DIV_W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic run,
	input wire logic [DIV_W-1:0] div,
	output logic tick
);
	logic [DIV_W-1:0] cnt_r;
	logic wrap;
	assign wrap = cnt_r == div;
	// Held at zero while stopped so each sync, SPI and I2C transfer starts with a full period
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else if (ce) begin
			if (!run || wrap) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
	assign tick = run & wrap & ce;
endmodule

// >>> mmsi_chk_properties.sv
// Port checker for the multi-mode serial channel
`timescale 1ns/1ps
module mmsi_chk import mmsi_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input mmsi_mode_t mode,
	input wire logic flow_en,
	input wire logic ss_hiz_en,
	input wire logic tx_ready,
	input wire logic tx_busy,
	input wire logic rx_full,
	input wire logic rx_read,
	input wire logic overrun_err,
	input wire logic err_clear,
	input wire logic i2c_cond_done,
	input wire logic serial_tx_output,
	input wire logic serial_tx_oe,
	input wire logic serial_clk_oe,
	input wire logic clear_to_send_input_n,
	input wire logic request_to_send_output_n,
	input wire logic spi_slave_select_input_n,
	input wire logic simple_i2c_clock_line_out,
	input wire logic simple_i2c_data_line_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_i2c_od; !simple_i2c_clock_line_out && !simple_i2c_data_line_out; endproperty
	a_i2c_od: assert property (p_i2c_od) else $error("i2c line driven high");
	property p_cond; i2c_cond_done |=> !i2c_cond_done; endproperty
	a_cond: assert property (p_cond) else $error("condition done too long");
	property p_smart_od; $stable(mode) && mode == MMSI_SMART |-> serial_tx_oe == !serial_tx_output;
	endproperty
	a_smart_od: assert property (p_smart_od) else $error("smart line not open drain");
	property p_ss_hiz;
		(mode == MMSI_SPI && ss_hiz_en && spi_slave_select_input_n)[*3]
			|-> !serial_tx_oe && !serial_clk_oe;
	endproperty
	a_ss_hiz: assert property (p_ss_hiz) else $error("spi outputs not floated");
	property p_rts; request_to_send_output_n == !(mode == MMSI_SYNC && flow_en && !rx_full);
	endproperty
	a_rts: assert property (p_rts) else $error("rts level wrong");
	property p_cts; mode == MMSI_SYNC && flow_en && clear_to_send_input_n |-> !tx_ready; endproperty
	a_cts: assert property (p_cts) else $error("send while cts high");
	property p_busy; tx_busy |-> !tx_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_read; rx_full && rx_read && ce |=> !rx_full; endproperty
	a_read: assert property (p_read) else $error("rx full after read");
	property p_ovr; overrun_err && !err_clear |=> overrun_err; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun lost");
	c_ovr: cover property (overrun_err);
	c_cond: cover property (i2c_cond_done);
	c_smart: cover property (mode == MMSI_SMART && tx_busy ##1 !tx_busy);
endmodule

bind mmsi_serial_channel mmsi_chk u_chk (.clk(clk), .resetn(resetn), .ce(ce), .mode(mode),
	.flow_en(flow_en), .ss_hiz_en(ss_hiz_en), .tx_ready(tx_ready), .tx_busy(tx_busy),
	.rx_full(rx_full), .rx_read(rx_read), .overrun_err(overrun_err), .err_clear(err_clear),
	.i2c_cond_done(i2c_cond_done), .serial_tx_output(serial_tx_output),
	.serial_tx_oe(serial_tx_oe), .serial_clk_oe(serial_clk_oe),
	.clear_to_send_input_n(clear_to_send_input_n),
	.request_to_send_output_n(request_to_send_output_n),
	.spi_slave_select_input_n(spi_slave_select_input_n),
	.simple_i2c_clock_line_out(simple_i2c_clock_line_out),
	.simple_i2c_data_line_out(simple_i2c_data_line_out));

// >>> mmsi_defines.svh
// Constants for the multi-mode serial channel
`ifndef MMSI_DEFINES_SVH
`define MMSI_DEFINES_SVH
`define MMSI_CLK_KHZ 20000
`define MMSI_I2C_FAST_KHZ 400
`define MMSI_I2C_FAST_DIV ((`MMSI_CLK_KHZ / (2 * `MMSI_I2C_FAST_KHZ)) - 1)
`define MMSI_OS_NORMAL 4'hF
`define MMSI_OS_DOUBLE 4'h7
`define MMSI_RX_FLT_LEN 2'h2
`define MMSI_LAST_BIT 4'h7
`define MMSI_I2C_ACK_BIT 4'h8
`define MMSI_I2C_STA_LAST 4'h3
`define MMSI_I2C_STP_LAST 4'h2
`define MMSI_RX_RST 8'h00
`endif

// >>> mmsi_noise_filter.sv
// Digital noise filter for one serial input line
`timescale 1ns/1ps
module mmsi_noise_filter #(
	parameter int LEN_W = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [LEN_W-1:0] len,
	input wire logic din,
	output logic dout
);
	logic [LEN_W-1:0] cnt_r;
	logic dout_r;
	logic differs;
	if (LEN_W < 1 || LEN_W > 8) begin : g_chk
		$error("mmsi_noise_filter: LEN_W out of range");
	end
	assign differs = din != dout_r;
	// Output follows only after len+1 samples of a steady new level
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_r <= '0;
			dout_r <= 1'b1;
		end else if (ce) begin
			if (!differs) begin
				cnt_r <= '0;
			end else if (cnt_r == len) begin
				cnt_r <= '0;
				dout_r <= din;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
	assign dout = dout_r;
endmodule

// >>> mmsi_peer_model.sv
// Far-side peer: loopback line, card error pull, I2C pull-ups
`timescale 1ns/1ps
module mmsi_peer_model import mmsi_pkg::*; (
	input wire logic clk,
	input mmsi_mode_t mode,
	input wire logic tx_out,
	input wire logic tx_oe,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic glitch,
	input wire logic card_err,
	output logic rx_line,
	output logic scl_line,
	output logic sda_line
);
	logic last_r = 1'b1;
	logic [8:0] etu_r = 9'h0;
	// Window assumes 16 clocks per etu; released plain line must not hold its value
	wire err_pull = card_err && etu_r >= 9'd168 && etu_r < 9'd184;
	wire drv = tx_oe ? tx_out : (mode == MMSI_SMART) ? 1'b1 : ~last_r;
	assign rx_line = drv & ~err_pull & ~glitch;
	assign scl_line = ~scl_oe;
	assign sda_line = ~sda_oe;
	always_ff @(posedge clk) begin
		last_r <= drv;
		if (etu_r != 9'h0)
			etu_r <= (etu_r == 9'd190) ? 9'h0 : etu_r + 9'h1;
		else if (!rx_line)
			etu_r <= 9'h1;
	end
endmodule

// >>> mmsi_pkg.sv
// Types for the multi-mode serial channel
package mmsi_pkg;
	typedef enum logic [2:0] {
		MMSI_ASYNC = 3'h0,
		MMSI_SYNC = 3'h1,
		MMSI_SMART = 3'h2,
		MMSI_I2C = 3'h3,
		MMSI_SPI = 3'h4
	} mmsi_mode_t;
	typedef enum logic [7:0] {
		T_IDLE = 8'h01,
		T_START = 8'h02,
		T_DATA = 8'h04,
		T_PAR = 8'h08,
		T_STOP = 8'h10,
		T_GUARD = 8'h20,
		T_I2C_STA = 8'h40,
		T_I2C_STP = 8'h80
	} mmsi_tx_st_t;
	typedef enum logic [5:0] {
		R_IDLE = 6'h01,
		R_START = 6'h02,
		R_DATA = 6'h04,
		R_PAR = 6'h08,
		R_STOP = 6'h10,
		R_ERR = 6'h20
	} mmsi_rx_st_t;
endpackage

// >>> mmsi_serial_channel.sv
// Multi-mode serial channel: async, clock sync, smart card, simple I2C and SPI
`timescale 1ns/1ps
`include "mmsi_defines.svh"
module mmsi_serial_channel import mmsi_pkg::*; #(
	parameter int DIV_W = 8,
	parameter int FLT_W = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input mmsi_mode_t mode,
	input wire logic [DIV_W-1:0] baud_div,
	input wire logic dbl_speed,
	input wire logic msb_first,
	input wire logic flow_en,
	input wire logic sc_inverse,
	input wire logic spi_cpol,
	input wire logic spi_cpha,
	input wire logic ss_hiz_en,
	input wire logic i2c_fast,
	input wire logic [FLT_W-1:0] filt_len,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_busy,
	input wire logic i2c_start_req,
	input wire logic i2c_stop_req,
	input wire logic i2c_ack_bit,
	output logic i2c_nack,
	output logic i2c_cond_done,
	output logic [7:0] rx_data,
	output logic rx_full,
	input wire logic rx_read,
	output logic overrun_err,
	output logic parity_err,
	input wire logic err_clear,
	input wire logic serial_rx_input,
	output logic serial_tx_output,
	output logic serial_tx_oe,
	output logic serial_clk_output,
	output logic serial_clk_oe,
	input wire logic clear_to_send_input_n,
	output logic request_to_send_output_n,
	input wire logic spi_slave_select_input_n,
	input wire logic simple_i2c_clock_line_in,
	output logic simple_i2c_clock_line_out,
	output logic simple_i2c_clock_line_oe,
	input wire logic simple_i2c_data_line_in,
	output logic simple_i2c_data_line_out,
	output logic simple_i2c_data_line_oe
);
	if (DIV_W < 5 || DIV_W > 16) begin : g_chk_div
		$error("mmsi_serial_channel: DIV_W must hold the fast I2C divisor");
	end
	if (FLT_W < 2) begin : g_chk_flt
		$error("mmsi_serial_channel: FLT_W too small for the receive filter");
	end

	mmsi_tx_st_t tx_st_r;
	mmsi_rx_st_t rx_st_r;
	logic [8:0] sh_r;
	logic [7:0] hold_r, rsh_r, rsh_nxt, rx_data_r;
	logic [3:0] cnt_r, os_r, rcnt_r, ros_r;
	logic ph_r, retry_r, scl_lo_r, sda_c_r, nack_r, cond_done_r;
	logic rx_full_r, overrun_r, parity_err_r, par_bad_r;

	// Mode decode
	logic is_async, is_sync, is_smart, is_i2c, is_spi, uart_like, half_mode;
	assign is_async = mode == MMSI_ASYNC;
	assign is_sync = mode == MMSI_SYNC;
	assign is_smart = mode == MMSI_SMART;
	assign is_i2c = mode == MMSI_I2C;
	assign is_spi = mode == MMSI_SPI;
	assign uart_like = is_async | is_smart;
	assign half_mode = is_sync | is_spi;

	// Input filters: receive line fixed, I2C lines adjustable
	logic [2:0] flt_in, flt_out;
	logic rxf, sclf, sdaf;
	assign flt_in = {simple_i2c_data_line_in, simple_i2c_clock_line_in, serial_rx_input};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_flt
			mmsi_noise_filter #(.LEN_W(FLT_W)) u_flt (
				.clk(clk),
				.resetn(resetn),
				.ce(ce),
				.len((gi == 0) ? FLT_W'(`MMSI_RX_FLT_LEN) : filt_len),
				.din(flt_in[gi]),
				.dout(flt_out[gi])
			);
		end
	endgenerate
	assign rxf = flt_out[0];
	assign sclf = flt_out[1];
	assign sdaf = flt_out[2];

	// Baud generator; fast I2C uses a fixed half-period divisor
	logic [DIV_W-1:0] div_eff;
	logic tick, baud_run;
	assign div_eff = (is_i2c && i2c_fast) ? DIV_W'(`MMSI_I2C_FAST_DIV) : baud_div;
	assign baud_run = uart_like | (tx_st_r != T_IDLE);
	mmsi_baud_gen #(.DIV_W(DIV_W)) u_baud (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.run(baud_run),
		.div(div_eff),
		.tick(tick)
	);

	// Bit timing and data format
	logic [3:0] os_max;
	logic conv, msb, os_end, ros_end, ros_half;
	assign os_max = dbl_speed ? `MMSI_OS_DOUBLE : `MMSI_OS_NORMAL;
	assign os_end = tick & (os_r == os_max);
	assign ros_end = tick & (ros_r == os_max);
	assign ros_half = tick & (ros_r == (os_max >> 1));
	assign conv = is_smart & sc_inverse;
	assign msb = msb_first | conv | is_i2c;

	logic tx_bit, tx_par, line_lvl;
	assign tx_bit = msb ? sh_r[7] : sh_r[0];
	assign tx_par = ^hold_r;
	// Inverse convention also inverts the parity bit but never the start bit
	assign line_lvl = (tx_st_r == T_START) ? 1'b0 :
		(tx_st_r == T_DATA) ? (tx_bit ^ conv) :
		(tx_st_r == T_PAR) ? (tx_par ^ conv) : 1'b1;

	// Clock phase handling for sync and SPI; sync behaves as polarity 1, phase 1
	logic cpol_e, cpha_e, lead, trail, smp, shf, half_last;
	assign cpol_e = is_sync | spi_cpol;
	assign cpha_e = is_sync | spi_cpha;
	assign lead = tick & ~ph_r;
	assign trail = tick & ph_r;
	assign smp = cpha_e ? trail : lead;
	assign shf = cpha_e ? (lead & (cnt_r != 4'h0)) : trail;
	assign half_last = trail & (cnt_r == `MMSI_LAST_BIT);

	logic cts_ok, take, i2c_rise;
	assign cts_ok = !(is_sync && flow_en) || !clear_to_send_input_n;
	assign tx_ready = (tx_st_r == T_IDLE) & cts_ok;
	assign take = tx_valid & tx_ready;
	// Clock stretching by a slave holds the high phase
	assign i2c_rise = tick & ph_r & sclf;

	// Transmit and master-side sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_st_r <= T_IDLE;
			sh_r <= '1;
			hold_r <= 8'hFF;
			cnt_r <= 4'h0;
			os_r <= 4'h0;
			ph_r <= 1'b0;
			retry_r <= 1'b0;
			scl_lo_r <= 1'b0;
			sda_c_r <= 1'b0;
			nack_r <= 1'b0;
			cond_done_r <= 1'b0;
		end else if (ce) begin
			cond_done_r <= 1'b0;
			if (tick) begin
				os_r <= (os_r == os_max) ? 4'h0 : os_r + 4'h1;
			end
			case (tx_st_r)
				T_IDLE: begin
					cnt_r <= 4'h0;
					os_r <= 4'h0;
					ph_r <= 1'b0;
					if (is_i2c && i2c_start_req) begin
						tx_st_r <= T_I2C_STA;
					end else if (is_i2c && i2c_stop_req) begin
						tx_st_r <= T_I2C_STP;
					end else if (take) begin
						hold_r <= tx_data;
						sh_r <= is_i2c ? {tx_data, i2c_ack_bit} : {1'b1, tx_data};
						tx_st_r <= uart_like ? T_START : T_DATA;
					end
				end
				T_START: begin
					if (os_end) begin
						tx_st_r <= T_DATA;
					end
				end
				T_DATA: begin
					if (uart_like) begin
						if (os_end) begin
							sh_r <= msb ? {sh_r[7:0], 1'b1} : {1'b1, sh_r[8:1]};
							cnt_r <= cnt_r + 4'h1;
							if (cnt_r == `MMSI_LAST_BIT) begin
								tx_st_r <= is_smart ? T_PAR : T_STOP;
							end
						end
					end else if (is_i2c) begin
						if (tick && !ph_r) begin
							ph_r <= 1'b1;
							scl_lo_r <= 1'b0;
						end else if (i2c_rise) begin
							ph_r <= 1'b0;
							scl_lo_r <= 1'b1;
							sh_r <= {sh_r[7:0], 1'b1};
							cnt_r <= cnt_r + 4'h1;
							if (cnt_r == `MMSI_I2C_ACK_BIT) begin
								nack_r <= sdaf;
								sda_c_r <= 1'b0;
								tx_st_r <= T_IDLE;
							end
						end
					end else begin
						if (tick) begin
							ph_r <= ~ph_r;
						end
						if (shf) begin
							sh_r <= msb ? {sh_r[7:0], 1'b1} : {1'b1, sh_r[8:1]};
						end
						if (trail) begin
							cnt_r <= cnt_r + 4'h1;
						end
						if (half_last) begin
							tx_st_r <= T_IDLE;
						end
					end
				end
				T_PAR: begin
					if (os_end) begin
						tx_st_r <= T_STOP;
					end
				end
				T_STOP: begin
					if (os_end) begin
						// Line is checked mid error window for a card complaint
						retry_r <= is_smart & ~rxf;
						tx_st_r <= is_smart ? T_GUARD : T_IDLE;
					end
				end
				T_GUARD: begin
					if (os_end) begin
						retry_r <= 1'b0;
						if (retry_r) begin
							sh_r <= {1'b1, hold_r};
							cnt_r <= 4'h0;
							tx_st_r <= T_START;
						end else begin
							tx_st_r <= T_IDLE;
						end
					end
				end
				T_I2C_STA: begin
					// Single master: the bus is driven without arbitration checks
					if (tick && (scl_lo_r || sclf)) begin
						cnt_r <= cnt_r + 4'h1;
						case (cnt_r)
							4'h0: sda_c_r <= 1'b0;
							4'h1: scl_lo_r <= 1'b0;
							4'h2: sda_c_r <= 1'b1;
							default: scl_lo_r <= 1'b1;
						endcase
						if (cnt_r == `MMSI_I2C_STA_LAST) begin
							cond_done_r <= 1'b1;
							tx_st_r <= T_IDLE;
						end
					end
				end
				T_I2C_STP: begin
					if (tick && (scl_lo_r || sclf)) begin
						cnt_r <= cnt_r + 4'h1;
						case (cnt_r)
							4'h0: sda_c_r <= 1'b1;
							4'h1: scl_lo_r <= 1'b0;
							default: sda_c_r <= 1'b0;
						endcase
						if (cnt_r == `MMSI_I2C_STP_LAST) begin
							cond_done_r <= 1'b1;
							tx_st_r <= T_IDLE;
						end
					end
				end
				default: tx_st_r <= T_IDLE;
			endcase
		end
	end

	// Asynchronous and smart card receiver
	logic rx_start_ok, rbit_uart, uart_load, par_fail;
	// Shared smart card line: own transmission is not received
	assign rx_start_ok = uart_like & ~rxf & ~(is_smart & tx_busy);
	assign rbit_uart = rxf ^ conv;
	assign uart_load = (rx_st_r == R_STOP) & ros_end & ~(is_smart & par_bad_r);
	assign par_fail = (rx_st_r == R_STOP) & ros_end & is_smart & par_bad_r;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_st_r <= R_IDLE;
			ros_r <= 4'h0;
			rcnt_r <= 4'h0;
			par_bad_r <= 1'b0;
		end else if (ce) begin
			if (tick) begin
				ros_r <= (ros_r == os_max) ? 4'h0 : ros_r + 4'h1;
			end
			case (rx_st_r)
				R_IDLE: begin
					ros_r <= 4'h0;
					rcnt_r <= 4'h0;
					if (rx_start_ok) begin
						rx_st_r <= R_START;
					end
				end
				R_START: begin
					if (ros_half) begin
						ros_r <= 4'h0;
						rx_st_r <= rxf ? R_IDLE : R_DATA;
					end
				end
				R_DATA: begin
					if (ros_end) begin
						rcnt_r <= rcnt_r + 4'h1;
						if (rcnt_r == `MMSI_LAST_BIT) begin
							rx_st_r <= is_smart ? R_PAR : R_STOP;
						end
					end
				end
				R_PAR: begin
					if (ros_end) begin
						par_bad_r <= rbit_uart != (^rsh_r);
						rx_st_r <= R_STOP;
					end
				end
				R_STOP: begin
					if (ros_end) begin
						rx_st_r <= par_fail ? R_ERR : R_IDLE;
					end
				end
				R_ERR: begin
					if (ros_end) begin
						rx_st_r <= R_IDLE;
					end
				end
				default: rx_st_r <= R_IDLE;
			endcase
		end
	end

	// Receive shifter shared by every mode
	logic rsh_en, rbit, half_load, i2c_load, rx_load, ovr_set;
	assign rsh_en = ((rx_st_r == R_DATA) & ros_end) |
		(half_mode & (tx_st_r == T_DATA) & smp) |
		(is_i2c & (tx_st_r == T_DATA) & i2c_rise & (cnt_r != `MMSI_I2C_ACK_BIT));
	assign rbit = uart_like ? rbit_uart : (is_i2c ? sdaf : serial_rx_input);
	assign rsh_nxt = !rsh_en ? rsh_r : (msb ? {rsh_r[6:0], rbit} : {rbit, rsh_r[7:1]});
	assign half_load = half_mode & (tx_st_r == T_DATA) & half_last;
	assign i2c_load = is_i2c & (tx_st_r == T_DATA) & i2c_rise & (cnt_r == `MMSI_LAST_BIT);
	assign rx_load = uart_load | half_load | i2c_load;
	// I2C replaces unread data since writes also clock in a byte
	assign ovr_set = rx_load & rx_full_r & ~rx_read & ~is_i2c;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rsh_r <= `MMSI_RX_RST;
			rx_data_r <= `MMSI_RX_RST;
			rx_full_r <= 1'b0;
			overrun_r <= 1'b0;
			parity_err_r <= 1'b0;
		end else if (ce) begin
			rsh_r <= rsh_nxt;
			if (rx_load && !ovr_set) begin
				rx_data_r <= rsh_nxt;
			end
			rx_full_r <= rx_load | (rx_full_r & ~rx_read);
			overrun_r <= ovr_set | (overrun_r & ~err_clear);
			parity_err_r <= par_fail | (parity_err_r & ~err_clear);
		end
	end

	// Pins
	logic spi_off, err_drive, sda_lo;
	assign spi_off = is_spi & ss_hiz_en & spi_slave_select_input_n;
	assign err_drive = is_smart & (rx_st_r == R_ERR);
	assign serial_tx_output = line_lvl & ~err_drive;
	// Smart card line is open drain so the card can pull it low
	assign serial_tx_oe = is_smart ? ~serial_tx_output : (~is_i2c & ~spi_off);
	assign serial_clk_output = ((tx_st_r == T_DATA) & half_mode) ? (cpol_e ^ ph_r) : cpol_e;
	assign serial_clk_oe = half_mode & ~spi_off;
	assign request_to_send_output_n = !(is_sync && flow_en && !rx_full_r);
	assign sda_lo = ((tx_st_r == T_DATA) & is_i2c) ? ~sh_r[8] : sda_c_r;
	assign simple_i2c_clock_line_out = 1'b0;
	assign simple_i2c_clock_line_oe = is_i2c & scl_lo_r;
	assign simple_i2c_data_line_out = 1'b0;
	assign simple_i2c_data_line_oe = is_i2c & sda_lo;

	assign tx_busy = tx_st_r != T_IDLE;
	assign i2c_nack = nack_r;
	assign i2c_cond_done = cond_done_r;
	assign rx_data = rx_data_r;
	assign rx_full = rx_full_r;
	assign overrun_err = overrun_r;
	assign parity_err = parity_err_r;
endmodule

// >>> testbench.sv
// Self-checking bench for the multi-mode serial channel
`timescale 1ns/1ps
module testbench import mmsi_pkg::*;;
	logic clk, resetn, ce, dbl_speed, msb_first, flow_en, sc_inverse, spi_cpol, spi_cpha;
	logic ss_hiz_en, i2c_fast, tx_valid, tx_ready, tx_busy, i2c_start_req, i2c_stop_req;
	logic i2c_ack_bit, i2c_nack, i2c_cond_done, rx_full, rx_read, overrun_err, parity_err;
	logic err_clear, serial_rx_input, serial_tx_output, serial_tx_oe, serial_clk_output;
	logic serial_clk_oe, clear_to_send_input_n, request_to_send_output_n, glitch, card_err;
	logic spi_slave_select_input_n, simple_i2c_clock_line_in, simple_i2c_clock_line_out;
	logic simple_i2c_clock_line_oe, simple_i2c_data_line_in, simple_i2c_data_line_out;
	logic simple_i2c_data_line_oe;
	logic [7:0] baud_div, tx_data, rx_data;
	logic [1:0] filt_len;
	mmsi_mode_t mode;
	int err_total = 0;
	int compares = 0;
	mmsi_serial_channel DUT (.clk, .resetn, .ce, .mode, .baud_div, .dbl_speed, .msb_first,
		.flow_en, .sc_inverse, .spi_cpol, .spi_cpha, .ss_hiz_en, .i2c_fast, .filt_len,
		.tx_data, .tx_valid, .tx_ready, .tx_busy, .i2c_start_req, .i2c_stop_req, .i2c_ack_bit,
		.i2c_nack, .i2c_cond_done, .rx_data, .rx_full, .rx_read, .overrun_err, .parity_err,
		.err_clear, .serial_rx_input, .serial_tx_output, .serial_tx_oe, .serial_clk_output,
		.serial_clk_oe, .clear_to_send_input_n, .request_to_send_output_n,
		.spi_slave_select_input_n, .simple_i2c_clock_line_in, .simple_i2c_clock_line_out,
		.simple_i2c_clock_line_oe, .simple_i2c_data_line_in, .simple_i2c_data_line_out,
		.simple_i2c_data_line_oe);
	mmsi_peer_model peer (.clk, .mode, .tx_out(serial_tx_output), .tx_oe(serial_tx_oe),
		.scl_oe(simple_i2c_clock_line_oe), .sda_oe(simple_i2c_data_line_oe), .glitch,
		.card_err, .rx_line(serial_rx_input), .scl_line(simple_i2c_clock_line_in),
		.sda_line(simple_i2c_data_line_in));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic results();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic send(input logic [7:0] d);
		@(posedge clk);
		tx_data <= d;
		tx_valid <= 1'b1;
		do @(negedge clk); while (tx_ready !== 1'b1);
		@(posedge clk);
		tx_valid <= 1'b0;
	endtask
	task automatic wait_idle();
		do @(negedge clk); while (tx_busy === 1'b1);
		repeat (4) @(negedge clk);
	endtask
	task automatic get_rx(input logic [7:0] e);
		int n;
		n = 0;
		while (rx_full !== 1'b1 && n < 6000) begin
			@(negedge clk);
			n++;
		end
		chk("rx_data", e, rx_data);
		@(posedge clk) rx_read <= 1'b1;
		@(posedge clk) rx_read <= 1'b0;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (i2c_cond_done !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk("cond_done", 1'b1, i2c_cond_done);
	endtask
	// Card character sent by pulling the shared line low through the glitch input
	task automatic card_send(input logic [7:0] d, input logic inv, input logic bad);
		logic [9:0] f;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++)
			f[i + 1] = inv ? ~d[7 - i] : d[i];
		f[9] = (^d) ^ bad ^ inv;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk) glitch <= ~f[i];
			repeat (15) @(posedge clk);
		end
		@(posedge clk) glitch <= 1'b0;
	endtask
	task automatic t_async(input logic dbl, input logic [15:0] len);
		int n;
		@(posedge clk);
		mode <= MMSI_ASYNC;
		dbl_speed <= dbl;
		send(8'hA5);
		n = 0;
		do @(negedge clk); while (serial_tx_output !== 1'b0);
		while (serial_tx_output === 1'b0) begin
			@(negedge clk);
			n++;
		end
		chk("start_len", len, n);
		get_rx(8'hA5);
	endtask
	task automatic t_glitch();
		@(posedge clk) glitch <= 1'b1;
		@(posedge clk) glitch <= 1'b0;
		repeat (400) @(negedge clk);
		chk("rx_full", 1'b0, rx_full);
	endtask
	task automatic t_sync();
		@(posedge clk);
		mode <= MMSI_SYNC;
		flow_en <= 1'b1;
		baud_div <= 8'h01;
		clear_to_send_input_n <= 1'b1;
		repeat (3) @(negedge clk);
		chk("tx_ready", 1'b0, tx_ready);
		chk("rts_n", 1'b0, request_to_send_output_n);
		@(posedge clk) clear_to_send_input_n <= 1'b0;
		send(8'h3C);
		wait_idle();
		chk("rts_n", 1'b1, request_to_send_output_n);
		send(8'hC3);
		wait_idle();
		chk("overrun", 1'b1, overrun_err);
		get_rx(8'h3C);
		@(posedge clk) err_clear <= 1'b1;
		@(posedge clk) err_clear <= 1'b0;
		@(negedge clk);
		chk("overrun", 1'b0, overrun_err);
	endtask
	task automatic t_spi();
		@(posedge clk);
		mode <= MMSI_SPI;
		flow_en <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			spi_cpol <= m[1];
			spi_cpha <= m[0];
			send(8'h5A ^ 8'(m));
			wait_idle();
			chk("clk_idle", m[1], serial_clk_output);
			get_rx(8'h5A ^ 8'(m));
		end
		@(posedge clk);
		ss_hiz_en <= 1'b1;
		spi_slave_select_input_n <= 1'b1;
		repeat (4) @(negedge clk);
		chk("tx_oe", 1'b0, serial_tx_oe);
		chk("clk_oe", 1'b0, serial_clk_oe);
		@(posedge clk) spi_slave_select_input_n <= 1'b0;
	endtask
	task automatic t_smart(input logic inv, input logic [7:0] d, input logic lvl);
		@(posedge clk);
		mode <= MMSI_SMART;
		sc_inverse <= inv;
		baud_div <= 8'h00;
		dbl_speed <= 1'b0;
		send(d);
		do @(negedge clk); while (serial_rx_input !== 1'b0);
		// Middle of the first data bit
		repeat (24) @(negedge clk);
		chk("first_bit", lvl, serial_rx_input);
		// Own frame is not received on the shared line, so the card answers
		wait_idle();
		card_send(d, inv, 1'b0);
		get_rx(d);
	endtask
	task automatic t_retry();
		int n;
		// Let the card's etu counter settle so its error window lines up
		repeat (200) @(posedge clk);
		card_err <= 1'b1;
		sc_inverse <= 1'b0;
		send(8'h33);
		do @(negedge clk); while (serial_rx_input !== 1'b0);
		repeat (186) @(negedge clk);
		@(posedge clk) card_err <= 1'b0;
		n = 0;
		while (serial_rx_input !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk("resend", 1'b1, n < 100);
		chk("tx_busy", 1'b1, tx_busy);
		wait_idle();
		card_send(8'h5A, 1'b0, 1'b1);
		repeat (19) @(negedge clk);
		chk("err_signal", 1'b0, serial_rx_input);
		chk("parity_err", 1'b1, parity_err);
		chk("rx_full", 1'b0, rx_full);
		@(posedge clk);
		rx_read <= 1'b1;
		err_clear <= 1'b1;
		@(posedge clk);
		rx_read <= 1'b0;
		err_clear <= 1'b0;
		@(negedge clk);
		chk("parity_err", 1'b0, parity_err);
	endtask
	task automatic t_i2c();
		int n;
		@(posedge clk);
		mode <= MMSI_I2C;
		i2c_fast <= 1'b1;
		i2c_start_req <= 1'b1;
		@(posedge clk) i2c_start_req <= 1'b0;
		wait_done();
		chk("sda", 1'b0, simple_i2c_data_line_in);
		send(8'h55);
		do @(negedge clk); while (simple_i2c_clock_line_oe !== 1'b0);
		do @(negedge clk); while (simple_i2c_clock_line_oe !== 1'b1);
		n = 0;
		while (simple_i2c_clock_line_oe === 1'b1) begin
			@(negedge clk);
			n++;
		end
		chk("scl_low", 16'd25, n);
		wait_idle();
		chk("nack", 1'b1, i2c_nack);
		@(posedge clk) i2c_stop_req <= 1'b1;
		@(posedge clk) i2c_stop_req <= 1'b0;
		wait_done();
		chk("sda", 1'b1, simple_i2c_data_line_in);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Whole run is well under 20k cycles
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		results();
	end
	initial begin
		{resetn, dbl_speed, msb_first, flow_en, sc_inverse, spi_cpol, spi_cpha} = 7'h00;
		{ss_hiz_en, i2c_fast, tx_valid, i2c_start_req, i2c_stop_req} = 5'h00;
		{rx_read, err_clear, glitch, card_err, clear_to_send_input_n} = 5'h00;
		ce = 1'b1;
		i2c_ack_bit = 1'b1;
		spi_slave_select_input_n = 1'b0;
		mode = MMSI_ASYNC;
		baud_div = 8'h00;
		tx_data = 8'h00;
		filt_len = 2'h1;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk("rx_full", 1'b0, rx_full);
		chk("tx_ready", 1'b1, tx_ready);
		chk("tx_line", 1'b1, serial_tx_output);
		t_async(1'b0, 16'd16);
		t_async(1'b1, 16'd8);
		t_glitch();
		t_sync();
		t_spi();
		t_smart(1'b0, 8'h01, 1'b1);
		t_smart(1'b1, 8'h80, 1'b0);
		t_retry();
		t_i2c();
		results();
	end
endmodule
